/* aes_btn.sv */
// On/off button: press edge and a long-hold pulse while output is off.
// Assumes the button level is already debounced and synchronous.
`timescale 1ns/1ps
module aes_btn #(
  parameter int HOLD_CYC = aes_pkg::HOLD_CYC
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic btn,
  input  wire logic out_off,
  output logic      press,
  output logic      hold
);
  logic        btn_ff;
  logic        fired_ff;
  logic [30:0] cnt_ff;

  assign press = btn && !btn_ff;
  assign hold  = btn && out_off && !fired_ff && (cnt_ff == 31'(HOLD_CYC - 1));

  // Edge history
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      btn_ff <= 1'b0;
    end else if (ce) begin
      btn_ff <= btn;
    end
  end

  // Hold timer restarts whenever the button drops or output turns on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff   <= 31'h00000000;
      fired_ff <= 1'b0;
    end else if (ce) begin
      if (!btn || !out_off) begin
        cnt_ff   <= 31'h00000000;
        fired_ff <= 1'b0;
      end else if (hold) begin
        fired_ff <= 1'b1;
      end else if (!fired_ff) begin
        cnt_ff <= cnt_ff + 31'h00000001;
      end
    end
  end
endmodule : aes_btn

/* aes_evt.sv */
// One user event: threshold compare, action, sticky status bit.
// Assumes value and threshold are synchronous to aclk.
`timescale 1ns/1ps
module aes_evt (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             en,
  input  wire logic             over,
  input  wire logic [15:0]      value,
  input  wire logic [15:0]      thr,
  input  wire aes_pkg::aes_act_t act,
  input  wire logic             clr,
  output logic                  stat_ff,
  output logic                  trip
);
  logic hit;

  // Only live while the terminal is on, and never for NONE
  always_comb begin
    hit  = en && (act != aes_pkg::ACT_NONE) && (over ? (value > thr) : (value < thr));
    trip = hit && (act == aes_pkg::ACT_ALARM);
  end

  // Sticky status; a new hit beats a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_ff <= 1'b0;
    end else if (ce) begin
      stat_ff <= (stat_ff & ~clr) | hit;
    end
  end
endmodule : aes_evt

/* aes_mst_model.sv */
// Master unit stand-in on the master-slave side of the supervisor.
// Assumes callers enter its tasks just after a rising aclk edge.
`timescale 1ns/1ps
module aes_mst_model (
  input  wire logic aclk,
  output logic      master_ctrl,
  output logic      master_ack,
  output logic      master_on,
  output logic      master_off,
  output logic      link_lost,
  output logic      link_reinit
);
  // Idle: not in control, link healthy
  initial begin
    {master_ctrl, master_ack, master_on, master_off, link_lost, link_reinit} = 6'h00;
  end

  task automatic set_ctrl(input logic c);
    master_ctrl <= c;
  endtask : set_ctrl

  task automatic set_link(input logic c);
    link_lost <= c;
  endtask : set_link

  // one-cycle ack, on, off or reinit
  task automatic pulse(input logic [3:0] k);
    {master_ack, master_on, master_off, link_reinit} <= k;
    @(posedge aclk);
    {master_ack, master_on, master_off, link_reinit} <= 4'h0;
  endtask : pulse
endmodule : aes_mst_model

/* aes_pkg.sv */
// Constants, register map and types shared by the alarm supervisor.
// Assumes one 100 MHz clock and 16-bit measurement words.
package aes_pkg;
  // Clock and timing
  localparam int CLK_HZ     = 100_000_000;
  localparam int HOLD_SEC   = 10;                 // Long press for slave reconfig
  localparam int HOLD_CYC   = HOLD_SEC * CLK_HZ;  // Above 4096: top parameter default
  // Measurement width and nominal ratings (plain defaults)
  localparam int MW         = 16;
  localparam logic [15:0] U_NOM   = 16'h1770;
  localparam logic [15:0] I_NOM   = 16'h0FA0;
  localparam logic [15:0] P_NOM   = 16'h2EE0;
  localparam logic [15:0] OPP_MAX = 16'(32'(P_NOM) * 11 / 10); // 1.1 x nominal
  localparam logic [23:0] RIGID_PCT = 24'h000065;   // 101 percent
  localparam logic [23:0] PCT_DEN   = 24'h000064;   // 100
  // Register byte offsets
  localparam int AW = 8;
  localparam logic [7:0] OFS_CTRL  = 8'h00;  // W: b0 on, b1 off, b2 ack
  localparam logic [7:0] OFS_OVP   = 8'h04;
  localparam logic [7:0] OFS_OCP   = 8'h08;
  localparam logic [7:0] OFS_OPP   = 8'h0C;
  localparam logic [7:0] OFS_EVT0  = 8'h10;  // Five event thresholds, 0x10..0x20
  localparam logic [7:0] OFS_ACT   = 8'h24;  // 2 bits per event
  localparam logic [7:0] OFS_STAT  = 8'h28;
  localparam logic [7:0] OFS_EVCLR = 8'h2C;  // Write one to clear event status
  // Control and status field positions
  localparam int CTL_ON = 0;
  localparam int CTL_OFF = 1;
  localparam int CTL_ACK = 2;
  localparam int ST_EVT = 8;
  localparam int ST_OUT = 16;
  localparam int ST_LED = 17;
  localparam int ST_MST = 18;
  // Alarm bit positions
  localparam int NAL = 8;
  localparam int AL_OVP = 0;
  localparam int AL_OCP = 1;
  localparam int AL_OPP = 2;
  localparam int AL_MAINS = 3;
  localparam int AL_HEAT = 4;
  localparam int AL_LINK = 5;
  localparam int AL_RIGID = 6;
  localparam int AL_EVT = 7;
  // Events: 0 low volt, 1 high volt, 2 low cur, 3 high cur, 4 high power
  localparam int NEV = 5;
  localparam logic [4:0] EVT_OVER = 5'h1A;
  // Reset values
  localparam logic [15:0] THR_RST = 16'hFFFF;
  localparam logic [15:0] EVT_RST = 16'h0000;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
  typedef enum logic [1:0] {ACT_NONE, ACT_SIGNAL, ACT_WARN, ACT_ALARM} aes_act_t;
  typedef enum logic {OUT_OFF, OUT_ON} aes_out_t;
endpackage : aes_pkg

/* aes_top.sv */
// Alarm and event supervisor for a slave power stage, AXI4-Lite registers.
// Assumes measurements and alarm inputs are synchronous to aclk.
// Summary of operation
// - Any alarm turns output off, lights LED.
// - Under master, report alarms; master acknowledges.
// - Else ack by button or remote command.
// - Press clears LED, next press turns on.
// - Voltage at threshold trips overvoltage alarm.
// - Current at threshold trips overcurrent alarm.
// - Power at threshold trips; limit 1.1 nominal.
// - Mains fault input trips fixed alarm.
// - Overheat input trips fixed alarm.
// - Link loss trips; clears only on reinit.
// - 60 V variant trips above 101% rated.
// - Event actions reset to none.
// - Events only while output on.
// - Five events with own action each.
// - Signal or warning sets status bit.
// - Alarm action sets status, output off.
// - Low voltage event below threshold.
// - High voltage event above threshold.
// - Low current event below threshold.
// - High current event above threshold.
// - High power event above threshold.
// - Ten second hold while off: slave mode.
//
// Added by the designer: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
module aes_top #(
  parameter int HOLD_CYC = aes_pkg::HOLD_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [15:0] meas_volt,
  input  wire logic [15:0] meas_curr,
  input  wire logic [15:0] meas_power,
  input  wire logic        mains_fault,
  input  wire logic        overheat,
  input  wire logic        link_lost,
  input  wire logic        link_reinit,
  input  wire logic        variant_60v,
  input  wire logic        master_ctrl,
  input  wire logic        master_ack,
  input  wire logic        master_on,
  input  wire logic        master_off,
  input  wire logic        onoff_btn,
  output logic             output_on,
  output logic             error_led,
  output logic [7:0]       alarm_report,
  output logic             slave_reconfig
);
  logic [7:0]        aw_addr_ff;
  logic              aw_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              w_ff;
  logic              do_wr;
  logic [31:0]       wval;
  logic [15:0]       ovp_thr_ff;
  logic [15:0]       ocp_thr_ff;
  logic [15:0]       opp_thr_ff;
  logic [15:0]       evt_thr_ff [aes_pkg::NEV];
  aes_pkg::aes_act_t evt_act_ff [aes_pkg::NEV];
  logic [4:0]        evt_stat;
  logic [4:0]        evt_trip;
  logic [4:0]        evt_clr;
  logic [7:0]        cause;
  logic [7:0]        latch_ff;
  logic [7:0]        nxt_latch;
  logic              ack;
  logic              btn_press;
  logic              btn_hold;
  logic              on_req;
  logic              off_req;
  logic              led;
  aes_pkg::aes_out_t state_ff;
  aes_pkg::aes_out_t nxt_state;

  // Mapped word addresses; shared by both bus paths
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= aes_pkg::OFS_EVCLR);
  endfunction : mapped

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction : merge

  // Measurement feeding each event
  function automatic logic [15:0] evt_val(input int i);
    evt_val = (i < 2) ? meas_volt : (i < 4) ? meas_curr : meas_power;
  endfunction : evt_val

  // Nominal ceiling for each event threshold
  function automatic logic [15:0] evt_nom(input int i);
    evt_nom = (i < 2) ? aes_pkg::U_NOM : (i < 4) ? aes_pkg::I_NOM : aes_pkg::P_NOM;
  endfunction : evt_nom

  // Status word read back
  function automatic logic [31:0] stat_word();
    stat_word = 32'h00000000;
    stat_word[aes_pkg::NAL-1:0]          = latch_ff;
    stat_word[aes_pkg::ST_EVT +: 5]      = evt_stat;
    stat_word[aes_pkg::ST_OUT]           = (state_ff == aes_pkg::OUT_ON);
    stat_word[aes_pkg::ST_LED]           = led;
    stat_word[aes_pkg::ST_MST]           = master_ctrl;
  endfunction : stat_word

  // Address and data taken in either order, one write at a time
  assign s_axi_awready = !aw_ff && !s_axi_bvalid;
  assign s_axi_wready  = !w_ff && !s_axi_bvalid;
  assign do_wr         = ce && aw_ff && w_ff && !s_axi_bvalid;
  assign wval          = merge(32'h00000000, w_data_ff, w_strb_ff);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff        <= 1'b0;
      w_ff         <= 1'b0;
      aw_addr_ff   <= 8'h00;
      w_data_ff    <= 32'h00000000;
      w_strb_ff    <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= aes_pkg::RESP_OK;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ff      <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ff      <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_ff        <= 1'b0;
        w_ff         <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(aw_addr_ff) ? aes_pkg::RESP_OK : aes_pkg::RESP_ERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= aes_pkg::RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= mapped(s_axi_araddr) ? aes_pkg::RESP_OK : aes_pkg::RESP_ERR;
        s_axi_rdata  <= 32'h00000000;
        case (s_axi_araddr)
          aes_pkg::OFS_OVP:  s_axi_rdata[15:0] <= ovp_thr_ff;
          aes_pkg::OFS_OCP:  s_axi_rdata[15:0] <= ocp_thr_ff;
          aes_pkg::OFS_OPP:  s_axi_rdata[15:0] <= opp_thr_ff;
          aes_pkg::OFS_STAT: s_axi_rdata       <= stat_word();
          aes_pkg::OFS_ACT: begin
            for (int i = 0; i < aes_pkg::NEV; i++) begin
              s_axi_rdata[2*i +: 2] <= evt_act_ff[i];
            end
          end
          default: begin
            for (int i = 0; i < aes_pkg::NEV; i++) begin
              if (s_axi_araddr == aes_pkg::OFS_EVT0 + 8'(4*i)) begin
                s_axi_rdata[15:0] <= evt_thr_ff[i];
              end
            end
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Protection thresholds; power limit clamped to its ceiling
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ovp_thr_ff <= aes_pkg::THR_RST;
      ocp_thr_ff <= aes_pkg::THR_RST;
      opp_thr_ff <= aes_pkg::OPP_MAX;
    end else if (do_wr) begin
      if (aw_addr_ff == aes_pkg::OFS_OVP) ovp_thr_ff <= wval[15:0];
      if (aw_addr_ff == aes_pkg::OFS_OCP) ocp_thr_ff <= wval[15:0];
      if (aw_addr_ff == aes_pkg::OFS_OPP) begin
        opp_thr_ff <= (wval[15:0] > aes_pkg::OPP_MAX) ? aes_pkg::OPP_MAX : wval[15:0];
      end
    end
  end

  // Per-event threshold, action and sticky status
  generate
    for (genvar g = 0; g < aes_pkg::NEV; g++) begin : g_evt
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          evt_thr_ff[g] <= aes_pkg::EVT_RST;
          evt_act_ff[g] <= aes_pkg::ACT_NONE;
        end else if (do_wr) begin
          if (aw_addr_ff == aes_pkg::OFS_EVT0 + 8'(4*g)) begin
            evt_thr_ff[g] <= (wval[15:0] > evt_nom(g)) ? evt_nom(g) : wval[15:0];
          end
          // takes effect at once, even while on
          if (aw_addr_ff == aes_pkg::OFS_ACT) begin
            evt_act_ff[g] <= aes_pkg::aes_act_t'(wval[2*g +: 2]);
          end
        end
      end
      assign evt_clr[g] = do_wr && (aw_addr_ff == aes_pkg::OFS_EVCLR) && wval[g];
      aes_evt u_evt (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .en      (state_ff == aes_pkg::OUT_ON),
        .over    (aes_pkg::EVT_OVER[g]),
        .value   (evt_val(g)),
        .thr     (evt_thr_ff[g]),
        .act     (evt_act_ff[g]),
        .clr     (evt_clr[g]),
        .stat_ff (evt_stat[g]),
        .trip    (evt_trip[g])
      );
    end
  endgenerate

  // Front button, with the long-hold slave reconfiguration
  aes_btn #(
    .HOLD_CYC (HOLD_CYC)
  ) u_btn (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .btn     (onoff_btn),
    .out_off (state_ff == aes_pkg::OUT_OFF),
    .press   (btn_press),
    .hold    (btn_hold)
  );
  assign slave_reconfig = ce && btn_hold && !master_ctrl;

  // Present alarm causes, evaluated whatever the output state except the event cause, live only while on
  always_comb begin
    cause = 8'h00;
    cause[aes_pkg::AL_OVP]   = meas_volt >= ovp_thr_ff;
    cause[aes_pkg::AL_OCP]   = meas_curr >= ocp_thr_ff;
    cause[aes_pkg::AL_OPP]   = meas_power >= opp_thr_ff;
    cause[aes_pkg::AL_MAINS] = mains_fault;
    cause[aes_pkg::AL_HEAT]  = overheat;
    cause[aes_pkg::AL_LINK]  = link_lost;
    // fixed 101 percent, scaled to avoid a divider
    cause[aes_pkg::AL_RIGID] = variant_60v &&
      (24'(meas_volt) * aes_pkg::PCT_DEN > 24'(aes_pkg::U_NOM) * aes_pkg::RIGID_PCT);
    // an alarm-action event counts as an alarm
    cause[aes_pkg::AL_EVT]   = |evt_trip;
  end

  // Acknowledge source depends on who is in control
  always_comb begin
    led = |latch_ff || |cause;
    // master acknowledges; button or command otherwise
    ack = master_ctrl ? master_ack :
          ((btn_press && led) ||
           (do_wr && aw_addr_ff == aes_pkg::OFS_CTRL && wval[aes_pkg::CTL_ACK]));
    // a press with LED lit only acknowledges
    on_req  = master_ctrl ? master_on :
              ((btn_press && !led) ||
               (do_wr && aw_addr_ff == aes_pkg::OFS_CTRL && wval[aes_pkg::CTL_ON]));
    off_req = master_ctrl ? master_off :
              ((btn_press && state_ff == aes_pkg::OUT_ON) ||
               (do_wr && aw_addr_ff == aes_pkg::OFS_CTRL && wval[aes_pkg::CTL_OFF]));
  end

  // Latched alarms; a live cause always wins over its clear
  always_comb begin
    nxt_latch = latch_ff | cause;
    // ack only clears alarms whose cause is gone
    if (ack) begin
      nxt_latch = (latch_ff & cause) | cause;
      nxt_latch[aes_pkg::AL_LINK] = latch_ff[aes_pkg::AL_LINK] | cause[aes_pkg::AL_LINK];
    end
    // link alarm clears only on reinitialisation
    if (link_reinit && !link_lost) begin
      nxt_latch[aes_pkg::AL_LINK] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_ff <= 8'h00;
    end else if (ce) begin
      latch_ff <= nxt_latch;
    end
  end

  // Output switch
  always_comb begin
    case (state_ff)
      aes_pkg::OUT_OFF: nxt_state = (on_req && !led) ? aes_pkg::OUT_ON : aes_pkg::OUT_OFF;
      // any alarm forces the output off
      aes_pkg::OUT_ON:  nxt_state = (|cause || off_req) ? aes_pkg::OUT_OFF : aes_pkg::OUT_ON;
      default:          nxt_state = aes_pkg::OUT_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= aes_pkg::OUT_OFF;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign output_on    = (state_ff == aes_pkg::OUT_ON);
  assign error_led    = |latch_ff;
  assign alarm_report = latch_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_alarm_off;
    ce && |cause |=> !output_on;
  endproperty
  a_alarm_off: assert property (p_alarm_off) else $error("output stayed on under alarm");

  property p_ovp;
    ce && meas_volt >= ovp_thr_ff |=> error_led && latch_ff[aes_pkg::AL_OVP];
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage not latched");

  property p_ocp;
    ce && meas_curr >= ocp_thr_ff |=> latch_ff[aes_pkg::AL_OCP];
  endproperty
  a_ocp: assert property (p_ocp) else $error("overcurrent not latched");

  property p_opp;
    opp_thr_ff <= aes_pkg::OPP_MAX;
  endproperty
  a_opp: assert property (p_opp) else $error("power threshold above ceiling");

  property p_mains;
    ce && mains_fault && output_on |=> !output_on && alarm_report[aes_pkg::AL_MAINS];
  endproperty
  a_mains: assert property (p_mains) else $error("mains fault ignored");

  property p_link_hold;
    ce && latch_ff[aes_pkg::AL_LINK] && !link_reinit |=> latch_ff[aes_pkg::AL_LINK];
  endproperty
  a_link_hold: assert property (p_link_hold) else $error("link alarm cleared early");

  property p_evt_off;
    ce && !output_on |-> evt_trip == 5'h00;
  endproperty
  a_evt_off: assert property (p_evt_off) else $error("event live while output off");

  property p_ack_btn;
    ce && !master_ctrl && btn_press && error_led && cause == 8'h00 &&
      !latch_ff[aes_pkg::AL_LINK] && !link_lost |=> !error_led ##1 !output_on;
  endproperty
  a_ack_btn: assert property (p_ack_btn) else $error("button did not acknowledge");

  property p_no_on_latched;
    ce && !output_on && error_led |=> !output_on;
  endproperty
  a_no_on_latched: assert property (p_no_on_latched) else $error("on while latched");

  c_alarm_ack: cover property (ce && error_led ##[1:20] !error_led);
  c_evt_alarm: cover property (ce && output_on && |evt_trip ##1 !output_on);
  c_reconfig:  cover property (slave_reconfig);
endmodule : aes_top

/* test_alarm_event_supervisor.sv */
// Self-checking bench: AXI4-Lite tasks and alarm, event, button scenarios.
// Assumes aes_top with a short hold count and the master stand-in.
`timescale 1ns/1ps
module test_alarm_event_supervisor;
  localparam int HC = 20;
  logic        aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, mains_fault, overheat, variant_60v;
  logic        onoff_btn, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, output_on, error_led, slave_reconfig, master_ctrl;
  logic        master_ack, master_on, master_off, link_lost, link_reinit;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, alarm_report;
  logic [31:0] s_axi_wdata, s_axi_rdata, ex;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] meas_volt, meas_curr, meas_power;
  int          err_total, n_checks, n_reconf, act;

  aes_top #(.HOLD_CYC(HC)) u_dut (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .meas_volt, .meas_curr, .meas_power, .mains_fault, .overheat, .link_lost,
    .link_reinit, .variant_60v, .master_ctrl, .master_ack, .master_on, .master_off, .onoff_btn,
    .output_on, .error_led, .alarm_report, .slave_reconfig);
  aes_mst_model u_mst (.aclk, .master_ctrl, .master_ack, .master_on, .master_off, .link_lost,
    .link_reinit);

  always #5 aclk = ~aclk;
  // Count reconfiguration pulses
  always @(posedge aclk) if (slave_reconfig === 1'b1) n_reconf++;

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  // Places above the last register answer with an error
  function automatic logic [31:0] er(input logic [7:0] a);
    return (a > aes_pkg::OFS_EVCLR) ? 32'(aes_pkg::RESP_ERR) : 32'(aes_pkg::RESP_OK);
  endfunction : er
  // Each channel released only at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk("bresp", 32'(s_axi_bresp), er(a));
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
    end
    @(posedge aclk); // Idle edge so the next call never re-drives bready
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic ta, tr;
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk("rdata", s_axi_rdata, exp);
      if (tr) chk("rresp", 32'(s_axi_rresp), er(a));
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tr) s_axi_rready <= 1'b0;
    end
    @(posedge aclk); // Idle edge so the next call never re-drives rready
  endtask : rd
  task automatic mset(input int i, input logic [15:0] v);
    case (i)
      0: meas_volt <= v;
      1: meas_curr <= v;
      default: meas_power <= v;
    endcase
  endtask : mset
  task automatic press();
    onoff_btn <= 1'b1;
    tick(3);
    onoff_btn <= 1'b0;
    tick(3);
  endtask : press
  // Expected {output_on, error_led, alarm_report}
  task automatic outs(input logic [9:0] e);
    chk("outs", {22'h0, output_on, error_led, alarm_report}, {22'h0, e});
  endtask : outs
  task automatic end_of_test();
    if (err_total == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #100us;
    err_total++;
    end_of_test();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h0;
    {s_axi_rready, mains_fault, overheat, variant_60v, onoff_btn} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, meas_volt, meas_curr, meas_power} = '0;
    {ce, s_axi_wstrb} = 5'h1F;
    {err_total, n_checks, n_reconf} = '0;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    outs(10'h000);
    rd(aes_pkg::OFS_OVP, 32'h0000FFFF);
    rd(aes_pkg::OFS_ACT, 32'h0);
    wr(8'h0C, 32'h0000FFFF);
    rd(8'h0C, 32'(aes_pkg::OPP_MAX));
    wr(8'h30, 32'h0000FFFF);
    rd(8'h30, 32'h0);
    // Partial strobe merges into zero
    s_axi_wstrb <= 4'h1;
    wr(8'h04, 32'hABCD1234);
    s_axi_wstrb <= 4'hF;
    rd(8'h04, 32'h00000034);
    wr(8'h10, 32'h0000FFFF);
    rd(8'h10, 32'(aes_pkg::U_NOM));
    // Protection trips at threshold, not one below
    for (int i = 0; i < 3; i++) begin
      wr(8'(4 + 4 * i), 32'h1000);
      wr(8'h00, 32'h1);
      mset(i, 16'h0FFF);
      tick(3);
      outs(10'h200);
      mset(i, 16'h1000);
      tick(3);
      outs({2'b01, 8'(1 << i)});
      mset(i, 16'h0000);
      tick(3);
      outs({2'b01, 8'(1 << i)});
      wr(8'h00, 32'h4);
      tick(3);
      outs(10'h000);
    end
    // Fixed alarms acknowledged by button
    for (int i = 3; i < 5; i++) begin
      wr(8'h00, 32'h1);
      {overheat, mains_fault} <= (i == 3) ? 2'b01 : 2'b10;
      tick(3);
      outs({2'b01, 8'(1 << i)});
      press();
      outs({2'b01, 8'(1 << i)});
      {mains_fault, overheat} <= 2'b00;
      tick(3);
      press();
      outs(10'h000);
      press();
      outs(10'h200);
      wr(8'h00, 32'h2);
    end
    wr(8'h04, 32'h0000FFFF);
    wr(8'h00, 32'h1);
    {variant_60v, meas_volt} <= {1'b1, 16'h17AC};
    tick(3);
    outs(10'h200);
    meas_volt <= 16'h17AD;
    tick(3);
    outs(10'h140);
    meas_volt <= 16'h0000;
    u_mst.set_link(1'b1);
    tick(3);
    outs(10'h160);
    u_mst.set_link(1'b0);
    wr(8'h00, 32'h4);
    tick(3);
    outs(10'h120);
    u_mst.pulse(4'h1);
    tick(3);
    outs(10'h000);
    // Clock enable low freezes output and latches
    wr(8'h00, 32'h1);
    {ce, mains_fault} <= 2'b01;
    tick(3);
    outs(10'h200);
    ce <= 1'b1;
    tick(3);
    outs(10'h108);
    mains_fault <= 1'b0;
    wr(8'h00, 32'h4);
    tick(3);
    outs(10'h000);
    // Master control: remote ack ignored, master ack works
    u_mst.set_ctrl(1'b1);
    u_mst.pulse(4'h4);
    tick(3);
    outs(10'h200);
    u_mst.pulse(4'h2);
    tick(3);
    outs(10'h000);
    overheat <= 1'b1;
    tick(3);
    overheat <= 1'b0;
    wr(8'h00, 32'h4);
    tick(3);
    outs(10'h110);
    rd(aes_pkg::OFS_STAT, 32'h00060010);
    u_mst.pulse(4'h8);
    tick(3);
    outs(10'h000);
    u_mst.set_ctrl(1'b0);
    for (int i = 0; i < 5; i++) begin
      act = (i % 3) + 1;
      wr(8'(16 + 4 * i), 32'h0800);
      wr(8'h24, 32'(act) << (2 * i));
      mset(i / 2, (i == 0 || i == 2) ? 16'h07FF : 16'h0801);
      tick(3);
      rd(8'h28, 32'h0);
      wr(8'h00, 32'h1);
      tick(3);
      ex = (act == 3) ? 32'h00020080 : 32'h00010000;
      rd(8'h28, ex | (32'h100 << i));
      mset(i / 2, 16'h0800);
      wr(8'h24, 32'h0);
      wr(8'h2C, 32'h1F);
      wr(8'h00, 32'h6);
      rd(8'h28, 32'h0);
    end
    // Long hold with lamp lit so the press only acknowledges
    mains_fault <= 1'b1;
    onoff_btn <= 1'b1;
    tick(10);
    onoff_btn <= 1'b0;
    tick(3);
    chk("reconf", n_reconf, 0);
    onoff_btn <= 1'b1;
    tick(HC + 5);
    onoff_btn <= 1'b0;
    tick(3);
    chk("reconf", n_reconf, 1);
    end_of_test();
  end
endmodule : test_alarm_event_supervisor
